//--- design/sram_pkg.sv
package sram_pkg;

   // ----------------------------------------------------------------
   // array geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W      = 19;  // word address width, wide variant
   localparam int LANES       = 4;   // byte lanes, wide variant (narrow: 2)
   localparam int BYTE_W      = 8;   // data bits per lane
   localparam int LANE_W      = 9;   // data plus one parity bit per lane
   localparam int BURST_W     = 2;   // burst counter works on the two lowest bits
   localparam int PARITY_POS  = 8;   // parity bit position inside a stored lane

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 5;  // 200 MHz
   localparam int SLEEP_CYC      = 2;  // cycles to enter or leave sleep
   localparam int READ_LATENCY   = 2;  // qualified edges from command to output stage

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic RST_BURST_ON = 1'b0;
   localparam logic RST_BURST_WR = 1'b0;
   localparam logic RST_SLEEP    = 1'b0;

   // ----------------------------------------------------------------
   // operation held in each pipeline stage
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      OP_IDLE  = 2'b00,   // deselect, nothing to do
      OP_READ  = 2'b01,   // read, dummy if the drive enable is off
      OP_WRITE = 2'b10,   // write of the selected lanes
      OP_SKIP  = 2'b11    // write abort, no lane written
   } op_t;

endpackage : sram_pkg

//--- design/sleep_sync.sv
`timescale 1ns/1ps
`default_nettype none

module sleep_sync
   import sram_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // asynchronous level in, synchronised level out
   input  wire logic level_async,
   output logic      level_sync
);

   // ----------------------------------------------------------------
   // two-stage synchroniser; stage one feeds stage two only
   // ----------------------------------------------------------------
   typedef struct packed {
      logic meta;
      logic sync;
   } sync_t;

   sync_t st_ff;
   sync_t nxt_st;

   always_comb begin
      nxt_st      = st_ff;
      nxt_st.meta = level_async;
      nxt_st.sync = st_ff.meta;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_ff <= '{meta: RST_SLEEP, sync: RST_SLEEP};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign level_sync = st_ff.sync;

endmodule : sleep_sync

`default_nettype wire

//--- design/burst_seq.sv
`timescale 1ns/1ps
`default_nettype none

module burst_seq
   import sram_pkg::*;
(
   // clock and reset
   input  wire logic               clk,
   input  wire logic               rst_n,
   // control, qualified by the caller
   input  wire logic               load,
   input  wire logic               advance,
   input  wire logic [BURST_W-1:0] load_low,
   input  wire logic               interleave,
   // low address bits of the next beat
   output logic      [BURST_W-1:0] next_low
);

   typedef struct packed {
      logic [BURST_W-1:0] base;
      logic [BURST_W-1:0] cnt;
      logic               ilv;
   } seq_t;

   seq_t               st_ff;
   seq_t               nxt_st;
   logic [BURST_W-1:0] cnt_inc;

   // wraps within four beats by plain overflow of the counter
   assign cnt_inc  = BURST_W'(st_ff.cnt + 1'b1);
   assign next_low = st_ff.ilv ? (st_ff.base ^ cnt_inc) :
                                 BURST_W'(st_ff.base + cnt_inc);

   always_comb begin
      nxt_st = st_ff;
      if (load) begin
         nxt_st.base = load_low;
         nxt_st.cnt  = '0;
         nxt_st.ilv  = interleave;
      end else if (advance) begin
         nxt_st.cnt = cnt_inc;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

endmodule : burst_seq

`default_nettype wire

//--- design/burst_sram.sv
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - all three chip selects active selects device
// - qualified load with strobe high starts read
// - advance continues burst, ignores selects and strobe
// - read with drive disabled is dummy read
// - advance with drive disabled: dummy read
// - load, strobe low, some lane: write burst
// - advance during write writes next address
// - write with no lanes selected is abort
// - continued beat without lanes advances, writes nothing
// - qualifier high outside sleep freezes whole pipeline state
// - write decided by strobe and lane selects
// - write cycle with a lane selected floats all lanes; an abort does not
// - powers up deselected, lanes floating
// - drive enable unsampled, masked during writes
// - read drives only when enabled and selected
// - output stage operation steers lane drivers
// - each selected lane writes own byte, parity
// - sleep request floats lanes, two cycles
// - burst counter linear or interleaved, wraps
// - burst keeps type latched at its load
module burst_sram
   import sram_pkg::*;
#(
   parameter int ADDR_BITS = sram_pkg::ADDR_W,
   parameter int NUM_LANES = sram_pkg::LANES
)(
   // clock and reset
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   // address and selects
   input  wire logic [ADDR_BITS-1:0]        address,
   input  wire logic                        chip_select_first_n,
   input  wire logic                        chip_select_second,
   input  wire logic                        chip_select_third_n,
   // cycle control
   input  wire logic                        advance_or_load,
   input  wire logic                        write_strobe_n,
   input  wire logic [NUM_LANES-1:0]        byte_lane_write_select_n,
   input  wire logic                        clock_qualify_n,
   input  wire logic                        burst_order_select,
   input  wire logic                        output_drive_n,
   input  wire logic                        sleep_request,
   // data lanes
   input  wire logic [BYTE_W*NUM_LANES-1:0] data_in,
   output logic      [BYTE_W*NUM_LANES-1:0] data_out,
   output logic                             data_oe_n,
   // parity lanes
   input  wire logic [NUM_LANES-1:0]        parity_lane_bus_in,
   output logic      [NUM_LANES-1:0]        parity_lane_bus_out,
   output logic                             parity_lane_bus_oe_n,
   // status
   output logic                             sleep_active
);

   import sram_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic                        burst_on;
      logic                        burst_wr;
      op_t                         s1_op;
      logic [ADDR_BITS-1:0]        s1_addr;
      logic [NUM_LANES-1:0]        s1_be;
      op_t                         s2_op;
      logic [ADDR_BITS-1:0]        s2_addr;
      logic [NUM_LANES-1:0]        s2_be;
      op_t                         out_op;
      logic [LANE_W*NUM_LANES-1:0] rd_word;
   } pipe_t;

   pipe_t                       st_ff;
   pipe_t                       nxt_st;
   logic [LANE_W*NUM_LANES-1:0] store_ff [2**ADDR_BITS];

   logic                        sleep_s;
   logic                        cs_on;
   logic                        qual_ok;
   logic                        no_lane;
   logic                        seq_load;
   logic                        seq_adv;
   logic [BURST_W-1:0]          seq_next;
   logic                        drive;

   // ----------------------------------------------------------------
   // sleep request crosses in through two flops; that gives the
   // two-cycle entry and exit
   // ----------------------------------------------------------------
   sleep_sync u_sleep (
      .clk         (clk),
      .rst_n       (rst_n),
      .level_async (sleep_request),
      .level_sync  (sleep_s)
   );

   assign sleep_active = sleep_s;

   // ----------------------------------------------------------------
   // burst address sequencer
   // ----------------------------------------------------------------
   burst_seq u_seq (
      .clk        (clk),
      .rst_n      (rst_n),
      .load       (seq_load),
      .advance    (seq_adv),
      .load_low   (address[BURST_W-1:0]),
      .interleave (burst_order_select),
      .next_low   (seq_next)
   );

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   assign cs_on   = !chip_select_first_n && chip_select_second && !chip_select_third_n;
   assign qual_ok = !clock_qualify_n && !sleep_s;
   assign no_lane = &byte_lane_write_select_n;

   always_comb begin
      nxt_st   = st_ff;
      seq_load = 1'b0;
      seq_adv  = 1'b0;
      if (sleep_s) begin
         // pending accesses are dropped; the array keeps its contents
         nxt_st.burst_on = RST_BURST_ON;
         nxt_st.s1_op    = OP_IDLE;
         nxt_st.s2_op    = OP_IDLE;
         nxt_st.out_op   = OP_IDLE;
      end else if (qual_ok) begin
         // move the pipeline one step
         nxt_st.s2_op   = st_ff.s1_op;
         nxt_st.s2_addr = st_ff.s1_addr;
         nxt_st.s2_be   = st_ff.s1_be;
         nxt_st.out_op  = st_ff.s2_op;
         if (st_ff.s2_op == OP_READ) begin
            nxt_st.rd_word = store_ff[st_ff.s2_addr];
         end
         if (advance_or_load) begin
            if (st_ff.burst_on) begin
               // selects and strobe are ignored here
               seq_adv        = 1'b1;
               nxt_st.s1_addr = {st_ff.s1_addr[ADDR_BITS-1:BURST_W], seq_next};
               if (st_ff.burst_wr) begin
                  nxt_st.s1_op = no_lane ? OP_SKIP : OP_WRITE;
                  nxt_st.s1_be = ~byte_lane_write_select_n;
               end else begin
                  nxt_st.s1_op = OP_READ;
                  nxt_st.s1_be = '0;
               end
            end else begin
               nxt_st.s1_op = OP_IDLE; // continued deselect
            end
         end else if (!cs_on) begin
            nxt_st.s1_op    = OP_IDLE;
            nxt_st.burst_on = 1'b0;
         end else begin
            seq_load        = 1'b1;
            nxt_st.burst_on = 1'b1;
            nxt_st.burst_wr = !write_strobe_n;
            nxt_st.s1_addr  = address;
            nxt_st.s1_be    = ~byte_lane_write_select_n;
            if (write_strobe_n) begin
               nxt_st.s1_op = OP_READ;
            end else if (no_lane) begin
               nxt_st.s1_op = OP_SKIP;
            end else begin
               nxt_st.s1_op = OP_WRITE;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_ff          <= '0;
         st_ff.burst_on <= RST_BURST_ON;
         st_ff.burst_wr <= RST_BURST_WR;
         st_ff.s1_op    <= OP_IDLE;
         st_ff.s2_op    <= OP_IDLE;
         st_ff.out_op   <= OP_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------
   // array write; lane data is taken on the second qualified edge
   // after the command, when the stage-two op is a write
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst_n && qual_ok && st_ff.s2_op == OP_WRITE) begin
         for (int l = 0; l < NUM_LANES; l++) begin
            if (st_ff.s2_be[l]) begin
               store_ff[st_ff.s2_addr][l*LANE_W +: LANE_W] <=
                  {parity_lane_bus_in[l], data_in[l*BYTE_W +: BYTE_W]};
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // lane drivers; the drive enable is used unsampled so it can
   // float the lanes mid-cycle, but a write in stage two masks it
   // ----------------------------------------------------------------
   assign drive = (st_ff.out_op == OP_READ) && !output_drive_n &&
                  !sleep_s && (st_ff.s2_op != OP_WRITE);

   assign data_oe_n            = !drive;
   assign parity_lane_bus_oe_n = !drive;

   for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
      assign data_out[g*BYTE_W +: BYTE_W] = st_ff.rd_word[g*LANE_W +: BYTE_W];
      assign parity_lane_bus_out[g]       = st_ff.rd_word[g*LANE_W + PARITY_POS];
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_cs_group: assert property (
      @(posedge clk) disable iff (!rst_n)
      (qual_ok && !advance_or_load && !cs_on) |=> (st_ff.s1_op == OP_IDLE && !st_ff.burst_on))
      else $error("partial chip select did not deselect");

   a_read_load: assert property (
      @(posedge clk) disable iff (!rst_n)
      (qual_ok && !advance_or_load && cs_on && write_strobe_n)
      |=> (st_ff.s1_op == OP_READ && st_ff.s1_addr == $past(address)))
      else $error("read load not taken at external address");

   a_burst_read: assert property (
      @(posedge clk) disable iff (!rst_n)
      (qual_ok && advance_or_load && st_ff.burst_on && !st_ff.burst_wr)
      |=> (st_ff.s1_op == OP_READ
           && st_ff.s1_addr[ADDR_BITS-1:BURST_W] == $past(st_ff.s1_addr[ADDR_BITS-1:BURST_W])))
      else $error("read burst did not continue");

   a_dummy_float: assert property (
      @(posedge clk) disable iff (!rst_n)
      output_drive_n |-> (data_oe_n && parity_lane_bus_oe_n))
      else $error("lanes driven with drive enable off");

   a_write_load: assert property (
      @(posedge clk) disable iff (!rst_n)
      (qual_ok && !advance_or_load && cs_on && !write_strobe_n && !no_lane)
      |=> (st_ff.s1_op == OP_WRITE && st_ff.burst_wr
           && st_ff.s1_be == ~$past(byte_lane_write_select_n)))
      else $error("write load not taken");

   a_write_beat: assert property (
      @(posedge clk) disable iff (!rst_n)
      (qual_ok && advance_or_load && st_ff.burst_on && st_ff.burst_wr && !no_lane)
      |=> (st_ff.s1_op == OP_WRITE && st_ff.s1_addr[BURST_W-1:0] != $past(st_ff.s1_addr[BURST_W-1:0])))
      else $error("write burst did not advance");

   a_write_abort: assert property (
      @(posedge clk) disable iff (!rst_n)
      (qual_ok && !advance_or_load && cs_on && !write_strobe_n && no_lane)
      |=> (st_ff.s1_op == OP_SKIP) ##1 (st_ff.s2_op == OP_SKIP || !$past(qual_ok)))
      else $error("abort not held as no-op");

   a_skip_beat: assert property (
      @(posedge clk) disable iff (!rst_n)
      (qual_ok && advance_or_load && st_ff.burst_on && st_ff.burst_wr && no_lane)
      |=> (st_ff.s1_op == OP_SKIP))
      else $error("empty write beat not skipped");

   a_stall_hold: assert property (
      @(posedge clk) disable iff (!rst_n)
      (clock_qualify_n && !sleep_s) |=> $stable(st_ff))
      else $error("pipeline moved on a stalled edge");

   a_write_float: assert property (
      @(posedge clk) disable iff (!rst_n)
      (st_ff.s2_op == OP_WRITE) |-> (data_oe_n && parity_lane_bus_oe_n))
      else $error("lanes driven during write data phase");

   a_reset_idle: assert property (
      @(posedge clk)
      !rst_n |=> (data_oe_n && parity_lane_bus_oe_n && st_ff.out_op == OP_IDLE))
      else $error("not deselected after reset");

   a_read_drive: assert property (
      @(posedge clk) disable iff (!rst_n)
      (st_ff.out_op == OP_READ && !output_drive_n && !sleep_s && st_ff.s2_op != OP_WRITE)
      |-> !data_oe_n)
      else $error("read data not driven");

   a_idle_float: assert property (
      @(posedge clk) disable iff (!rst_n)
      (st_ff.out_op != OP_READ) |-> data_oe_n)
      else $error("lanes driven outside a read");

   a_sleep_float: assert property (
      @(posedge clk) disable iff (!rst_n)
      sleep_request ##1 sleep_request |=> (sleep_active && data_oe_n ##1 st_ff.out_op == OP_IDLE))
      else $error("sleep not entered in two cycles");

   a_type_kept: assert property (
      @(posedge clk) disable iff (!rst_n)
      (qual_ok && advance_or_load) |=> $stable(st_ff.burst_wr))
      else $error("burst type changed mid burst");

   a_read_latency: assert property (
      @(posedge clk) disable iff (!rst_n)
      (st_ff.s1_op == OP_READ && qual_ok) ##1 qual_ok |=> (st_ff.out_op == OP_READ))
      else $error("read data not in output stage after two edges");

   a_dummy_cont: assert property (
      @(posedge clk) disable iff (!rst_n)
      (qual_ok && advance_or_load && st_ff.burst_on && !st_ff.burst_wr && output_drive_n)
      |=> (st_ff.s1_op == OP_READ
           && st_ff.s1_addr[BURST_W-1:0] != $past(st_ff.s1_addr[BURST_W-1:0])))
      else $error("dummy read did not advance");

   a_write_decide: assert property (
      @(posedge clk) disable iff (!rst_n)
      (qual_ok && !advance_or_load && cs_on && no_lane) |=> (st_ff.s1_op != OP_WRITE))
      else $error("write taken without a lane select");

   a_drive_async: assert property (
      @(posedge clk) disable iff (!rst_n)
      (st_ff.out_op == OP_READ && st_ff.s2_op != OP_WRITE && !sleep_s)
      |-> (data_oe_n == output_drive_n))
      else $error("drive enable not followed directly");

   a_lane_write: assert property (
      @(posedge clk) disable iff (!rst_n)
      (qual_ok && st_ff.s2_op == OP_WRITE && st_ff.s2_be[0])
      |=> (store_ff[$past(st_ff.s2_addr)][LANE_W-1:0]
           == {$past(parity_lane_bus_in[0]), $past(data_in[BYTE_W-1:0])}))
      else $error("selected lane zero not written");

   a_cont_deselect: assert property (
      @(posedge clk) disable iff (!rst_n)
      (qual_ok && advance_or_load && !st_ff.burst_on) |=> (st_ff.s1_op == OP_IDLE))
      else $error("continued deselect started an access");

endmodule : burst_sram

`default_nettype wire

//--- tb/sram_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

module sram_ctrl_model #(
   parameter int AB = 6,
   parameter int CW = AB + 13
)(
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rst_n,
   // device status and bench requests
   input  wire logic          sleep_active,
   input  wire logic [CW-1:0] req_ctl,
   input  wire logic [35:0]   req_data,
   // device side
   output logic      [CW-1:0] ctl = '0,
   output logic      [35:0]   bus_drv = '0,
   output logic               bus_en = 1'b0
);
   // --------
   // burst tracking, mirrors what was issued
   // --------
   logic        open_ff = 1'b0;
   logic        wr_ff = 1'b0;
   logic        pend_ff = 1'b0;
   logic [35:0] hold_ff = '0;
   wire         sel = !ctl[12] && ctl[11] && !ctl[10];
   wire         wr_now = ctl[9] ? open_ff && wr_ff : sel && !ctl[8];

   // requests reach the pins at the falling edge
   always @(negedge clk) ctl <= req_ctl;

   // an aborted beat gets no data, so a read still in the output stage never collides
   always @(posedge clk) begin
      if (!rst_n) begin
         open_ff <= 1'b0;
         pend_ff <= 1'b0;
         bus_en  <= 1'b0;
      end else if (!ctl[3] && !sleep_active) begin
         if (!ctl[9]) begin
            open_ff <= sel;
            wr_ff   <= !ctl[8];
         end
         pend_ff <= wr_now && !(&ctl[7:4]);
         hold_ff <= req_data;
         bus_en  <= pend_ff;
         bus_drv <= pend_ff ? hold_ff : ~bus_drv;
      end
   end
endmodule : sram_ctrl_model

`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
   import sram_pkg::*;
   localparam int AB = 6;
   typedef struct packed {
      logic [AB-1:0] a;
      logic          cs1n, cs2, cs3n, adv, we_n;
      logic [3:0]    bl;
      logic          cq_n, bos, drv_n, slp;
   } req_t;
   typedef struct packed {
      op_t           op;
      logic [AB-1:0] a;
      logic [3:0]    l;
   } stg_t;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   req_t        rq = '0;
   req_t        pin;
   logic [35:0] wd = '0;
   logic [35:0] drv;
   logic        bus_en, data_oe_n, parity_lane_bus_oe_n, sleep_active;
   logic [31:0] data_out;
   logic [3:0]  parity_lane_bus_out;
   wire  [31:0] dq = !data_oe_n ? data_out : drv[31:0];
   wire  [3:0]  dp = !parity_lane_bus_oe_n ? parity_lane_bus_out : drv[35:32];
   int          n_mismatch = 0;
   int          check_count = 0;
   stg_t        s1m, s2m, c;
   op_t         outm;
   logic [31:0] rdm, md [64];
   logic [3:0]  rpm, mp [64];
   logic        bo, bw, bil, z1, z2;
   logic [AB-1:0] bb;
   logic [1:0]  bn;

   sram_ctrl_model #(.AB(AB)) sram_ctrl_model_i (
      .clk(clk), .rst_n(rst_n), .sleep_active(sleep_active), .req_ctl(rq),
      .req_data(wd), .ctl(pin), .bus_drv(drv), .bus_en(bus_en));

   burst_sram #(.ADDR_BITS(AB), .NUM_LANES(4)) burst_sram_i (
      .clk(clk), .rst_n(rst_n), .address(pin.a),
      .chip_select_first_n(pin.cs1n), .chip_select_second(pin.cs2),
      .chip_select_third_n(pin.cs3n), .advance_or_load(pin.adv),
      .write_strobe_n(pin.we_n), .byte_lane_write_select_n(pin.bl),
      .clock_qualify_n(pin.cq_n), .burst_order_select(pin.bos),
      .output_drive_n(pin.drv_n), .sleep_request(pin.slp),
      .data_in(dq), .data_out(data_out), .data_oe_n(data_oe_n),
      .parity_lane_bus_in(dp), .parity_lane_bus_out(parity_lane_bus_out),
      .parity_lane_bus_oe_n(parity_lane_bus_oe_n), .sleep_active(sleep_active));

   initial begin
      forever #(CLK_PERIOD_NS / 2.0) clk = ~clk;
   end

   // --------
   // expectation helpers
   // --------
   function automatic logic p(int n);
      return ($urandom % n) == 0;
   endfunction : p

   function automatic logic [AB-1:0] ba(logic [AB-1:0] b, logic [1:0] n, logic il);
      return {b[AB-1:2], il ? b[1:0] ^ n : b[1:0] + n};
   endfunction : ba

   function automatic req_t cmd(logic [AB-1:0] a, logic we_n, logic [3:0] bl);
      req_t r;
      r = '0;
      r.a = a;
      r.cs2 = 1'b1;
      r.we_n = we_n;
      r.bl = bl;
      return r;
   endfunction : cmd

   function automatic req_t rnd();
      req_t r;
      r = cmd(AB'($urandom), p(2), 4'($urandom));
      r.cs1n = p(8);
      r.cs2 = !p(8);
      r.cs3n = p(8);
      r.adv = p(2);
      r.cq_n = p(8);
      r.bos = p(2);
      r.drv_n = p(4);
      return r;
   endfunction : rnd

   // reference of the pipeline, fed from the pins the device sees
   always @(posedge clk) begin
      if (!rst_n) begin
         s1m = '0;
         s2m = '0;
         outm = OP_IDLE;
         bo = 1'b0;
         z1 = 1'b0;
         z2 = 1'b0;
      end else begin
         if (z2) begin
            s1m = '0;
            s2m = '0;
            outm = OP_IDLE;
            bo = 1'b0;
         end else if (!pin.cq_n) begin
            c = '0;
            c.l = pin.bl;
            if (!pin.adv) begin
               bo = !pin.cs1n && pin.cs2 && !pin.cs3n;
               bw = !pin.we_n;
               bil = pin.bos;
               bb = pin.a;
               bn = 2'd0;
            end else
               bn = bn + 2'd1;
            c.a = ba(bb, bn, bil);
            if (bo) c.op = !bw ? OP_READ : (&pin.bl ? OP_SKIP : OP_WRITE);
            if (s2m.op == OP_READ) begin
               rdm = md[s2m.a];
               rpm = mp[s2m.a];
            end
            if (s2m.op == OP_WRITE) for (int k = 0; k < 4; k++) if (!s2m.l[k]) begin
               md[s2m.a][8*k+:8] = dq[8*k+:8];
               mp[s2m.a][k] = dp[k];
            end
            outm = s2m.op;
            s2m = s1m;
            s1m = c;
         end
         z2 = z1;
         z1 = pin.slp;
      end
   end

   // --------
   // checking and bus cycles
   // --------
   task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_of_test

   // the drive enable is looked at mid-cycle, 1 ns after the falling edge that puts it on the pins
   task automatic step(req_t r);
      logic e;
      @(posedge clk);
      #1;
      rq = r;
      wd = {4'($urandom), $urandom};
      @(negedge clk);
      #1;
      e = outm == OP_READ && !pin.drv_n && !z2 && s2m.op != OP_WRITE;
      check("sleep_active", sleep_active, z2);
      check("data_oe_n", data_oe_n, !e);
      check("parity_oe_n", parity_lane_bus_oe_n, !e);
      if (e) begin
         check("data_out", data_out, rdm);
         check("parity_out", parity_lane_bus_out, rpm);
      end
      check("bus_clash", bus_en & !data_oe_n, 1'b0);
   endtask : step

   initial begin
      req_t r;
      req_t ds;
      void'($urandom(32'hdef7e0de));
      ds = cmd('0, 1'b1, 4'hf);
      ds.cs2 = 1'b0;
      repeat (10) step(ds);
      rst_n = 1'b1;
      for (int i = 0; i < 64; i++) step(cmd(AB'(i), 1'b0, 4'h0));
      for (int i = 0; i < 16; i++) begin
         step(cmd(6'h09, 1'b0, 4'(i)));
         step(cmd(6'h09, 1'b1, 4'h0));
         // an idle slot keeps the next write out of stage two while the read is out
         step(ds);
      end
      // selects and strobe flip during the beats and must be ignored
      for (int t = 0; t < 2; t++) begin
         r = cmd(6'h0e, 1'(t), 4'h0);
         r.bos = 1'(t);
         step(r);
         r.adv = 1'b1;
         r.cs2 = 1'b0;
         r.we_n = !r.we_n;
         repeat (5) step(r);
      end
      r = ds;
      repeat (3) step(r);
      r.slp = 1'b1;
      repeat (6) step(r);
      r.slp = 1'b0;
      repeat (4) step(r);
      for (int i = 0; i < 2000; i++) begin
         if (i == 700) rst_n = 1'b0;
         if (i == 702) rst_n = 1'b1;
         step(rnd());
      end
      end_of_test();
   end

   initial begin
      #50000;
      n_mismatch++;
      end_of_test();
   end
endmodule : tb

`default_nettype wire
